// ### hdl/host_port.sv
// host parallel port: strobe capture, nibble pairing and read-back drive
`timescale 1ns/1ns
module host_port
  import lcd_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       register_select,
  input  wire logic       read_write_select,
  input  wire logic       strobe,
  input  wire logic [7:0] host_bus_in,
  input  wire logic       width8,
  input  wire logic [7:0] read_word,
  output logic      [7:0] host_bus_out,
  output logic      [7:0] host_bus_oe_n,
  output host_cmd_s       cmd
);

  port_state_s s_q;
  port_state_s s_d;

  assign host_bus_out  = s_q.out;
  assign host_bus_oe_n = s_q.oe_n;
  assign cmd           = s_q.cmd;

  // a transfer completes on the falling strobe, as the host bus cycle ends there
  always_comb begin
    s_d           = s_q;
    s_d.cmd.valid = 1'b0;
    s_d.strobe_d  = strobe;
    s_d.oe_n      = 8'hFF;
    if (strobe && read_write_select) begin
      if (width8) begin
        s_d.out  = read_word;
        s_d.oe_n = 8'h00;
      end else begin
        s_d.out  = s_q.second ? {read_word[3:0], 4'h0} : {read_word[7:4], 4'h0};
        s_d.oe_n = 8'h0F;
      end
    end
    if (s_q.strobe_d && !strobe) begin
      s_d.cmd.rs = register_select;
      s_d.cmd.rw = read_write_select;
      if (width8) begin
        s_d.cmd.valid = 1'b1;
        s_d.cmd.data  = host_bus_in;
        s_d.second    = 1'b0;
      end else if (!s_q.second) begin
        s_d.hi_nib = host_bus_in[7:4];
        s_d.second = 1'b1;
      end else begin
        s_d.cmd.valid = 1'b1;
        s_d.cmd.data  = {s_q.hi_nib, host_bus_in[7:4]};
        s_d.second    = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q      <= '0;
      s_q.oe_n <= 8'hFF;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

endmodule : host_port

// ### hdl/lcd_engine.sv
// character display instruction engine with register bus slave
`timescale 1ns/1ns
module lcd_engine
  import lcd_pkg::*;
#(
  parameter int CLEAR_CNT = CLEAR_CYCLES,
  parameter int CMD_CNT   = CMD_CYCLES,
  parameter int DATA_CNT  = DATA_CYCLES,
  parameter int BLINK_CNT = BLINK_CYCLES
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic      [1:0]            bresp,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic      [31:0]           rdata,
  output logic      [1:0]            rresp,
  input  wire logic                  register_select,
  input  wire logic                  read_write_select,
  input  wire logic                  strobe,
  input  wire logic [7:0]            host_bus_in,
  output logic      [7:0]            host_bus_out,
  output logic      [7:0]            host_bus_oe_n,
  output panel_out_s                 panel
);

  localparam logic [CNT_W-1:0] CLEAR_N = CNT_W'(CLEAR_CNT);
  localparam logic [CNT_W-1:0] CMD_N   = CNT_W'(CMD_CNT);
  localparam logic [CNT_W-1:0] DATA_N  = CNT_W'(DATA_CNT);
  localparam logic [CNT_W-1:0] BLINK_N = CNT_W'(BLINK_CNT - 1);

  engine_state_s s_q;
  engine_state_s s_d;
  host_cmd_s     cmd;
  ram_wr_s       ram_wr;
  logic [7:0]    ram_rd;
  logic          busy;
  logic [7:0]    read_word;
  logic [31:0]   status_word;
  logic [31:0]   mode_word;

  // address step with the wrap points of each memory and line mode
  function automatic logic [6:0] step_addr(input logic [6:0] a,
                                           input logic       up,
                                           input logic       glyph,
                                           input logic       two);
    logic [6:0] r;
    r = a;
    if (glyph) begin
      r = {1'b0, (up ? a[5:0] + 6'h01 : a[5:0] - 6'h01)};
    end else if (two) begin
      if (up) begin
        r = (a == LINE1_END) ? LINE2_START : (a == LINE2_END) ? HOME_ADDR : a + 7'h01;
      end else begin
        r = (a == LINE2_START) ? LINE1_END : (a == HOME_ADDR) ? LINE2_END : a - 7'h01;
      end
    end else begin
      if (up) begin
        r = (a == ONE_LINE_END) ? HOME_ADDR : a + 7'h01;
      end else begin
        r = (a == HOME_ADDR) ? ONE_LINE_END : a - 7'h01;
      end
    end
    return r;
  endfunction : step_addr

  // display offset within one line; both lines use the same offset but wrap on their own
  function automatic logic [6:0] step_shift(input logic [6:0] sh,
                                            input logic       left,
                                            input logic       two);
    logic [6:0] top;
    top = two ? SHIFT_MAX_2L : SHIFT_MAX_1L;
    if (left) begin
      return (sh >= top) ? 7'h00 : sh + 7'h01;
    end
    return (sh == 7'h00 || sh > top) ? top : sh - 7'h01;
  endfunction : step_shift

  host_port u_port (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .ce                (ce),
    .register_select   (register_select),
    .read_write_select (read_write_select),
    .strobe            (strobe),
    .host_bus_in       (host_bus_in),
    .width8            (s_q.width8),
    .read_word         (read_word),
    .host_bus_out      (host_bus_out),
    .host_bus_oe_n     (host_bus_oe_n),
    .cmd               (cmd)
  );

  text_glyph_ram u_ram (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .wr       (ram_wr),
    .rd_glyph (s_q.glyph_sel),
    .rd_addr  (s_q.ac),
    .rd_data  (ram_rd)
  );

  // busy covers both the timed execution and the clear walk
  assign busy        = (s_q.busy_cnt != '0) || s_q.clear_run;
  assign read_word   = cmd_rs_view(s_q.dout, busy, s_q.ac, register_select);
  assign status_word = {22'h0, s_q.clear_run, s_q.glyph_sel, busy, s_q.ac};
  assign mode_word   = {17'h0, s_q.shift, s_q.tall, s_q.two_line, s_q.width8, s_q.blink,
                        s_q.cursor_on, s_q.visible, s_q.scroll, s_q.increment};

  // read-back selection follows the live select pin during the strobe
  function automatic logic [7:0] cmd_rs_view(input logic [7:0] dout,
                                             input logic       bsy,
                                             input logic [6:0] ac,
                                             input logic       rs);
    return rs ? dout : {bsy, ac};
  endfunction : cmd_rs_view

  assign awready = s_q.awready;
  assign wready  = s_q.wready;
  assign bvalid  = s_q.bvalid;
  assign bresp   = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid  = s_q.rvalid;
  assign rdata   = s_q.rdata;
  assign rresp   = s_q.rresp;
  assign panel   = s_q.panel;

  // memory write port: the clear walk and data writes never overlap since writes wait on busy
  always_comb begin
    ram_wr = '0;
    if (s_q.clear_run) begin
      ram_wr.we   = 1'b1;
      ram_wr.addr = s_q.clear_idx;
      ram_wr.data = SPACE_CODE;
    end else if (cmd.valid && s_q.port_en && cmd.rs && !cmd.rw && !busy) begin
      ram_wr.we    = 1'b1;
      ram_wr.glyph = s_q.glyph_sel;
      ram_wr.addr  = s_q.ac;
      ram_wr.data  = cmd.data;
    end
  end

  // next state of the instruction engine and the bus slave
  always_comb begin
    s_d = s_q;
    if (s_q.busy_cnt != '0) begin
      s_d.busy_cnt = s_q.busy_cnt - 1'b1;
    end
    // output data register is loaded late in the busy time, when the read address has settled
    if (s_q.fetch && s_q.busy_cnt == CNT_W'(1)) begin
      s_d.dout  = ram_rd;
      s_d.fetch = 1'b0;
    end
    if (s_q.clear_run) begin
      s_d.clear_idx = s_q.clear_idx + 7'h01;
      if (s_q.clear_idx == TEXT_LAST) begin
        s_d.clear_run = 1'b0;
      end
    end
    // host instructions; a busy device ignores all but the status read
    if (cmd.valid && s_q.port_en && !(!cmd.rs && cmd.rw) && !busy) begin
      if (cmd.rs && !cmd.rw) begin
        s_d.ac       = step_addr(s_q.ac, s_q.increment, s_q.glyph_sel, s_q.two_line);
        s_d.busy_cnt = DATA_N;
        if (s_q.scroll) begin
          s_d.shift = step_shift(s_q.shift, s_q.increment, s_q.two_line);
        end
      end else if (cmd.rs && cmd.rw) begin
        s_d.ac       = step_addr(s_q.ac, s_q.increment, s_q.glyph_sel, s_q.two_line);
        s_d.fetch    = 1'b1;
        s_d.busy_cnt = DATA_N;
      end else if (cmd.data[7]) begin
        s_d.ac        = cmd.data[6:0];
        s_d.glyph_sel = 1'b0;
        s_d.fetch     = 1'b1;
        s_d.busy_cnt  = CMD_N;
      end else if (cmd.data[6]) begin
        s_d.ac        = {1'b0, cmd.data[5:0]};
        s_d.glyph_sel = 1'b1;
        s_d.fetch     = 1'b1;
        s_d.busy_cnt  = CMD_N;
      end else if (cmd.data[5]) begin
        s_d.width8   = cmd.data[4];
        s_d.two_line = cmd.data[3];
        s_d.tall     = cmd.data[2];
        s_d.busy_cnt = CMD_N;
      end else if (cmd.data[4]) begin
        if (cmd.data[3]) begin
          s_d.shift = step_shift(s_q.shift, !cmd.data[2], s_q.two_line);
        end else begin
          s_d.ac    = step_addr(s_q.ac, cmd.data[2], s_q.glyph_sel, s_q.two_line);
          s_d.fetch = !s_q.glyph_sel;
        end
        s_d.busy_cnt = CMD_N;
      end else if (cmd.data[3]) begin
        s_d.visible   = cmd.data[2];
        s_d.cursor_on = cmd.data[1];
        s_d.blink     = cmd.data[0];
        s_d.busy_cnt  = CMD_N;
      end else if (cmd.data[2]) begin
        s_d.increment = cmd.data[1];
        s_d.scroll    = cmd.data[0];
        s_d.busy_cnt  = CMD_N;
      end else if (cmd.data[1]) begin
        s_d.ac        = HOME_ADDR;
        s_d.shift     = 7'h00;
        s_d.glyph_sel = 1'b0;
        s_d.busy_cnt  = CLEAR_N;
      end else if (cmd.data[0]) begin
        s_d.clear_run = 1'b1;
        s_d.clear_idx = 7'h00;
        s_d.ac        = HOME_ADDR;
        s_d.shift     = 7'h00;
        s_d.glyph_sel = 1'b0;
        s_d.increment = 1'b1;
        s_d.busy_cnt  = CLEAR_N;
      end
    end
    // blink phase runs free; the solid phase stands for the all-dots pattern
    if (s_q.blink_cnt >= BLINK_N) begin
      s_d.blink_cnt = '0;
      s_d.blink_ph  = !s_q.blink_ph;
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 1'b1;
    end
    s_d.panel.visible     = s_q.visible;
    s_d.panel.cursor_on   = s_q.cursor_on && s_q.visible;
    s_d.panel.blink_solid = s_q.blink && s_q.blink_ph && s_q.visible;
    s_d.panel.two_line    = s_q.two_line;
    s_d.panel.tall_font   = s_q.tall;
    s_d.panel.shift       = s_q.shift;
    s_d.panel.cursor_addr = s_q.ac;

    // write channels: address and data taken in either order, answered once both are in
    if (awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = {awaddr[7:2], 2'b00};
    end
    if (wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = wdata[7:0];
      s_d.wstrb0 = wstrb[0];
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      if (s_q.awaddr == CTRL_OFS) begin
        s_d.bresp = RESP_OKAY;
        if (s_q.wstrb0) begin
          s_d.port_en = s_q.wdata[0];
        end
      end else begin
        s_d.bresp = RESP_SLVERR; // read-only or unmapped
      end
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;

    // read channel: one outstanding read, answered the edge after it is taken
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      if ({araddr[7:2], 2'b00} == CTRL_OFS) begin
        s_d.rdata = {31'h0, s_q.port_en};
      end else if ({araddr[7:2], 2'b00} == STATUS_OFS) begin
        s_d.rdata = status_word;
      end else if ({araddr[7:2], 2'b00} == MODE_OFS) begin
        s_d.rdata = mode_word;
      end else begin
        s_d.rdata = 32'h0;
        s_d.rresp = RESP_SLVERR;
      end
    end
    s_d.arready = !s_d.rvalid;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q           <= '0;
      s_q.width8    <= WIDTH8_RST;
      s_q.increment <= INCR_RST;
      s_q.port_en   <= PORT_EN_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

endmodule : lcd_engine

// ### hdl/lcd_pkg.sv
// shared constants, types and state records for the character display instruction engine
package lcd_pkg;

  // register bus map, byte addresses of aligned 32-bit words
  localparam int           AXI_ADDR_W  = 8;
  localparam logic [7:0]   CTRL_OFS    = 8'h00;
  localparam logic [7:0]   STATUS_OFS  = 8'h04;
  localparam logic [7:0]   MODE_OFS    = 8'h08;
  localparam logic [1:0]   RESP_OKAY   = 2'h0;
  localparam logic [1:0]   RESP_SLVERR = 2'h2;
  localparam logic         PORT_EN_RST = 1'b1;

  // text and glyph memory layout
  localparam int           TEXT_DEPTH   = 128;
  localparam int           GLYPH_DEPTH  = 64;
  localparam logic [7:0]   SPACE_CODE   = 8'h20;
  localparam logic [6:0]   HOME_ADDR    = 7'h00;
  localparam logic [6:0]   LINE1_END    = 7'h27;
  localparam logic [6:0]   LINE2_START  = 7'h40;
  localparam logic [6:0]   LINE2_END    = 7'h67;
  localparam logic [6:0]   ONE_LINE_END = 7'h4F;
  localparam logic [6:0]   TEXT_LAST    = 7'h7F;
  localparam logic [6:0]   SHIFT_MAX_2L = 7'h27;
  localparam logic [6:0]   SHIFT_MAX_1L = 7'h4F;

  // mode values after reset
  localparam logic         WIDTH8_RST   = 1'b1;
  localparam logic         INCR_RST     = 1'b1;

  // execution times and their cycle counts at the 250 MHz clock, rounded up
  localparam int           CLK_MHZ        = 250;
  localparam int           CLEAR_TIME_NS  = 1530000;
  localparam int           CMD_TIME_NS    = 39000;
  localparam int           DATA_TIME_NS   = 43000;
  localparam int           CLEAR_CYCLES   = (CLEAR_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int           CMD_CYCLES     = (CMD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int           DATA_CYCLES    = (DATA_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int           BLINK_CYCLES   = 4194304;
  localparam int           CNT_W          = 24;

  // one host command, one 8-bit bus cycle or two 4-bit bus cycles assembled to a whole byte
  typedef struct packed {
    logic       valid;
    logic       rs;
    logic       rw;
    logic [7:0] data;
  } host_cmd_s;

  // one write into text or glyph memory
  typedef struct packed {
    logic       we;
    logic       glyph;
    logic [6:0] addr;
    logic [7:0] data;
  } ram_wr_s;

  // state presented to the panel drive
  typedef struct packed {
    logic       visible;
    logic       cursor_on;
    logic       blink_solid;
    logic       two_line;
    logic       tall_font;
    logic [6:0] shift;
    logic [6:0] cursor_addr;
  } panel_out_s;

  // host port state
  typedef struct packed {
    logic       strobe_d;
    logic       second;
    logic [3:0] hi_nib;
    logic [7:0] out;
    logic [7:0] oe_n;
    host_cmd_s  cmd;
  } port_state_s;

  // instruction engine state
  typedef struct packed {
    logic [CNT_W-1:0] busy_cnt;
    logic             clear_run;
    logic [6:0]       clear_idx;
    logic             fetch;
    logic [6:0]       ac;
    logic             glyph_sel;
    logic             increment;
    logic             scroll;
    logic             visible;
    logic             cursor_on;
    logic             blink;
    logic             width8;
    logic             two_line;
    logic             tall;
    logic [6:0]       shift;
    logic [7:0]       dout;
    logic             port_en;
    logic [CNT_W-1:0] blink_cnt;
    logic             blink_ph;
    panel_out_s       panel;
    logic             awready;
    logic             wready;
    logic             aw_have;
    logic             w_have;
    logic [7:0]       awaddr;
    logic [7:0]       wdata;
    logic             wstrb0;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } engine_state_s;

endpackage : lcd_pkg

// ### hdl/text_glyph_ram.sv
// text memory and glyph memory with one write port and one registered read port
`timescale 1ns/1ns
module text_glyph_ram
  import lcd_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire ram_wr_s    wr,
  input  wire logic       rd_glyph,
  input  wire logic [6:0] rd_addr,
  output logic      [7:0] rd_data
);

  logic [7:0] text_mem  [TEXT_DEPTH];
  logic [7:0] glyph_mem [GLYPH_DEPTH];

  // memories carry no reset; only the read register does
  always_ff @(posedge aclk) begin
    if (ce && wr.we) begin
      if (wr.glyph) begin
        glyph_mem[wr.addr[5:0]] <= wr.data;
      end else begin
        text_mem[wr.addr] <= wr.data;
      end
    end
  end

  // read data lags the address by one edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= 8'h00;
    end else if (ce) begin
      rd_data <= rd_glyph ? glyph_mem[rd_addr[5:0]] : text_mem[rd_addr];
    end
  end

endmodule : text_glyph_ram

// ### tb/host_model.sv
// host processor model on the parallel port, 8-bit or 4-bit transfers
`timescale 1ns/1ns
module host_model (
  input  wire logic       aclk,
  input  wire logic [7:0] host_bus_out,
  input  wire logic [7:0] host_bus_oe_n,
  output logic            register_select,
  output logic            read_write_select,
  output logic            strobe,
  output logic      [7:0] host_bus_in
);
  logic       wide = 1'b1; // host's bus width, switched by the bench
  logic [7:0] oe_seen = 8'hFF;
  initial begin
    register_select = 1'b0;
    read_write_select = 1'b0;
    strobe = 1'b0;
    host_bus_in = 8'h5A;
  end
  // one strobe pulse; lines hold past the sampled fall
  task automatic beat(input logic rs, input logic rw, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge aclk);
    register_select <= rs;
    read_write_select <= rw;
    host_bus_in <= rw ? ~host_bus_in : d; // released lines never repeat old data
    strobe <= 1'b1;
    repeat (3) @(posedge aclk);
    q = host_bus_out;
    oe_seen = host_bus_oe_n;
    strobe <= 1'b0;
    @(posedge aclk);
    host_bus_in <= ~host_bus_in;
  endtask : beat
  // lower lines carry the other nibble as junk in narrow mode
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    if (wide) begin
      beat(rs, rw, d, q);
    end else begin
      beat(rs, rw, {d[7:4], d[3:0]}, hi);
      beat(rs, rw, {d[3:0], d[7:4]}, lo);
      q = {hi[7:4], lo[7:4]};
    end
  endtask : xfer
endmodule : host_model

// ### tb/lcd_engine_assertions.sv
// port checker for the instruction engine
`timescale 1ns/1ns
module lcd_engine_assertions
  import lcd_pkg::*;
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  ce,
  input wire logic                  awvalid,
  input wire logic                  awready,
  input wire logic                  wvalid,
  input wire logic                  wready,
  input wire logic                  bvalid,
  input wire logic                  bready,
  input wire logic [1:0]            bresp,
  input wire logic                  arvalid,
  input wire logic                  arready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic                  rvalid,
  input wire logic                  rready,
  input wire logic [31:0]           rdata,
  input wire logic [1:0]            rresp,
  input wire logic                  strobe,
  input wire logic [7:0]            host_bus_oe_n,
  input wire panel_out_s            panel
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // read answers come one cycle after the take, write answers two, and both stand until accepted
  a_b_answer: assert property (ce && awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("write response late");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_r_answer: assert property (ce && arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_r_unmapped: assert property (arvalid && arready && araddr == 8'h10
    |=> rresp == RESP_SLVERR && rdata == 32'h0) else $error("unmapped read accepted");
  a_ready_gate: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  // three cycles covers the registered strobe lag
  a_oe_idle: assert property (!strobe [*3] |-> host_bus_oe_n == 8'hFF)
    else $error("bus driven without strobe");
  a_cursor_vis: assert property (panel.cursor_on |-> panel.visible)
    else $error("cursor shown on blank panel");
  a_blink_vis: assert property (panel.blink_solid |-> panel.visible)
    else $error("blink shown on blank panel");
  c_wr_err: cover property (bvalid && bresp == RESP_SLVERR);
  c_rd_err: cover property (rvalid && rresp == RESP_SLVERR);
  c_blink: cover property (panel.blink_solid);
  c_narrow: cover property (host_bus_oe_n == 8'h0F);
endmodule : lcd_engine_assertions

bind lcd_engine lcd_engine_assertions i_chk (.aclk, .aresetn, .ce, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
  .rready, .rdata, .rresp, .strobe, .host_bus_oe_n, .panel);

// ### tb/lcd_engine_test.sv
// self-checking bench: register bus and host port of the instruction engine
`timescale 1ns/1ns
module lcd_engine_test
  import lcd_pkg::*;
();
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic        arready, rvalid, register_select, read_write_select, strobe;
  logic [7:0]  awaddr, araddr, host_bus_in, host_bus_out, host_bus_oe_n, q;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        ce = 1'b1;
  logic [3:0]  wstrb = 4'hF;
  panel_out_s  panel;
  int          err_count = 0;
  int          check_count = 0;
  logic [6:0]  ac_t [4] = '{7'h27, 7'h40, 7'h40, 7'h40};
  logic [31:0] md_t [4] = '{32'hE0, 32'hE0, 32'h1E0, 32'hE0};
  always #2 aclk = ~aclk;
  lcd_engine #(.CLEAR_CNT(200), .CMD_CNT(8), .DATA_CNT(8), .BLINK_CNT(16)) i_dut (
    .aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .register_select, .read_write_select, .strobe,
    .host_bus_in, .host_bus_out, .host_bus_oe_n, .panel);
  host_model i_host (.aclk, .host_bus_out, .host_bus_oe_n, .register_select,
    .read_write_select, .strobe, .host_bus_in);
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // every polling loop waits through here so a hang ends the run
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 2000) begin
      err_count++;
      $display("[ERR] %0t wait ran out", $time);
      print_verdict();
    end
  endtask : tick
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n = 0;
    logic ta = 1'b0;
    logic tw = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      tick(n);
      ta = ta | (awready & awvalid);
      tw = tw | (wready & wvalid);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!(ta && tw));
    while (!bvalid) tick(n);
    bready <= 1'b0;
    check({32'h0, bresp}, {32'h0, er});
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      tick(n);
      if (arready && arvalid) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    check({rresp, rdata}, {er, ex});
  endtask : axi_rd
  // busy must show at once, then poll it low and leave a margin
  task automatic idle();
    logic [7:0] s;
    int         n = 0;
    i_host.xfer(1'b0, 1'b1, 8'h00, s);
    check({26'h0, s[7]}, 34'h1);
    while (s[7]) begin
      tick(n);
      i_host.xfer(1'b0, 1'b1, 8'h00, s);
    end
    tick(n);
  endtask : idle
  task automatic cmd(input logic rs, input logic rw, input logic [7:0] d);
    i_host.xfer(rs, rw, d, q);
    idle();
  endtask : cmd
  task automatic ac_is(input logic [6:0] a);
    logic [7:0] s;
    i_host.xfer(1'b0, 1'b1, 8'h00, s);
    check({26'h0, s}, {27'h0, a});
  endtask : ac_is
  task automatic rd(input logic [7:0] e);
    cmd(1'b1, 1'b1, 8'h00);
    check({26'h0, q}, {26'h0, e});
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(CTRL_OFS, 32'h1, RESP_OKAY);
    axi_rd(MODE_OFS, 32'h21, RESP_OKAY);
    axi_rd(8'h10, 32'h0, RESP_SLVERR);
    axi_wr(STATUS_OFS, 32'hFF, RESP_SLVERR);
    axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
    i_host.xfer(1'b0, 1'b0, 8'h0F, q); // port off, so ignored
    axi_rd(MODE_OFS, 32'h21, RESP_OKAY);
    axi_wr(CTRL_OFS, 32'h1, RESP_OKAY);
    // a frozen engine must miss a whole host transfer
    ce <= 1'b0;
    i_host.xfer(1'b0, 1'b0, 8'h0F, q);
    ce <= 1'b1;
    axi_rd(MODE_OFS, 32'h21, RESP_OKAY);
    // lane 0 strobed off leaves the port enable as it was
    wstrb <= 4'h0;
    axi_wr(CTRL_OFS, 32'h0, RESP_OKAY);
    wstrb <= 4'hF;
    axi_rd(CTRL_OFS, 32'h1, RESP_OKAY);
    cmd(1'b0, 1'b0, 8'h01);
    cmd(1'b0, 1'b0, 8'h3C);
    cmd(1'b0, 1'b0, 8'h0F);
    axi_rd(MODE_OFS, 32'hFD, RESP_OKAY);
    cmd(1'b0, 1'b0, 8'h0D);
    axi_rd(MODE_OFS, 32'hF5, RESP_OKAY);
    check({33'h0, panel.cursor_on}, 34'h0);
    cmd(1'b0, 1'b0, 8'h08);
    check({33'h0, panel.visible}, 34'h0);
    cmd(1'b0, 1'b0, 8'hA7);
    cmd(1'b1, 1'b0, 8'h41);
    cmd(1'b1, 1'b0, 8'h42);
    ac_is(7'h41);
    cmd(1'b0, 1'b0, 8'hA7);
    rd(8'h41);
    rd(8'h42);
    cmd(1'b0, 1'b0, 8'h04);
    cmd(1'b0, 1'b0, 8'hC1);
    rd(8'h20);
    ac_is(7'h40);
    for (int i = 0; i < 4; i++) begin
      cmd(1'b0, 1'b0, 8'h10 | 8'(i << 2));
      ac_is(ac_t[i]);
      axi_rd(MODE_OFS, md_t[i], RESP_OKAY);
    end
    cmd(1'b0, 1'b0, 8'h07);
    cmd(1'b1, 1'b0, 8'h43);
    axi_rd(MODE_OFS, 32'h1E3, RESP_OKAY);
    cmd(1'b0, 1'b0, 8'h05);
    cmd(1'b1, 1'b0, 8'h44);
    axi_rd(MODE_OFS, 32'hE2, RESP_OKAY);
    cmd(1'b0, 1'b0, 8'h06);
    cmd(1'b0, 1'b0, 8'h7F);
    cmd(1'b1, 1'b0, 8'h55);
    ac_is(7'h00);
    cmd(1'b0, 1'b0, 8'h7F);
    rd(8'h55);
    cmd(1'b0, 1'b0, 8'h18);
    cmd(1'b0, 1'b0, 8'h02);
    ac_is(7'h00);
    axi_rd(MODE_OFS, 32'hE1, RESP_OKAY);
    cmd(1'b0, 1'b0, 8'h80);
    rd(8'h20);
    i_host.xfer(1'b0, 1'b0, 8'h28, q);
    i_host.wide = 1'b0;
    idle();
    axi_rd(MODE_OFS, 32'h41, RESP_OKAY);
    cmd(1'b0, 1'b0, 8'h85);
    cmd(1'b1, 1'b0, 8'hC3);
    cmd(1'b0, 1'b0, 8'h85);
    rd(8'hC3);
    check({26'h0, i_host.oe_seen}, 34'h0F);
    cmd(1'b0, 1'b0, 8'h01);
    cmd(1'b0, 1'b0, 8'h85);
    rd(8'h20);
    print_verdict();
  end
endmodule : lcd_engine_test
